//--- usb_out_ep_status.sv
`timescale 1ns/1ns
`include "usb_out_ep_regs.svh"

module usb_out_ep_status
    import usb_out_ep_pkg::*;
(
    // clock, reset and enable
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // apb slave
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [7:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    // packet engine side
    input  wire logic       rx_valid,
    input  wire logic [9:0] rx_len,
    output logic            rx_ready,
    output logic            flush_req,
    // status to the core
    output logic            packet_ready_flag,
    output logic            out_buffer_full,
    output logic            lost_packet_flag,
    output logic            double_buffer_enable,
    output logic            iso_mode,
    output logic      [9:0] rx_byte_count
);

    ep_state_t  st_ff;
    ep_state_t  nxt_st;
    logic [1:0] q_count;
    logic [9:0] q_head;
    logic       push;
    logic       pop;
    logic       acc_done;
    logic       wr_low;
    logic       wr_high;
    logic [7:0] ctrl_low_val;

    // ======================================================
    // address decode, used only for the error answer; the read path compares paddr itself
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == `ADDR_CTRL_LOW)  || (a == `ADDR_CTRL_HIGH) ||
               (a == `ADDR_COUNT_LOW) || (a == `ADDR_COUNT_HIGH);
    endfunction : addr_mapped

    // ======================================================
    // fifo occupancy and flags; ready, full and count come from queue state, the rest from the state register
    assign packet_ready_flag = (q_count != 2'h0);
    // full compares against the limit for the current mode
    assign out_buffer_full = st_ff.dbl ?
                             (q_count >= `PKTS_DOUBLE) :
                             (q_count >= `PKTS_SINGLE);
    // stalling the engine keeps a packet from landing in a full fifo
    assign rx_ready  = ~out_buffer_full & ce;
    assign push      = rx_valid & rx_ready;
    // count is zero while no packet waits; only valid with ready
    assign rx_byte_count = packet_ready_flag ? q_head :
                           `COUNT_RST;
    assign lost_packet_flag     = st_ff.lost;
    assign double_buffer_enable = st_ff.dbl;
    assign iso_mode             = st_ff.iso;
    assign flush_req            = st_ff.flush_pend;

    // ======================================================
    // apb handshake: one wait-free access phase after setup
    assign pready   = (st_ff.apb == ST_ACCESS) & psel & penable & ce;
    assign pslverr  = st_ff.slverr & pready;
    assign prdata   = {24'h000000, st_ff.prdata};
    assign acc_done = pready;
    assign wr_low   = acc_done & pwrite & ~st_ff.slverr &
                      (paddr == `ADDR_CTRL_LOW);
    assign wr_high  = acc_done & pwrite & ~st_ff.slverr &
                      (paddr == `ADDR_CTRL_HIGH);

    // software unload writes ready as zero; a pending flush also pops
    assign pop = (wr_low & ~pwdata[`BIT_PKT_READY]) |
                 st_ff.flush_pend;

    // ======================================================
    // control low byte as read back
    always_comb begin
        ctrl_low_val                = 8'h00;
        ctrl_low_val[`BIT_PKT_READY] = packet_ready_flag;
        ctrl_low_val[`BIT_BUF_FULL]  = out_buffer_full;
        ctrl_low_val[`BIT_LOST_PKT]  = st_ff.lost;
        ctrl_low_val[`BIT_FLUSH]     = st_ff.flush_pend;
    end

    // ======================================================
    // next state of the slave and control bits
    always_comb begin
        nxt_st = st_ff;
        // apb phase tracking; read data is captured at setup
        unique case (st_ff.apb)
            ST_IDLE: begin
                // a setup edge that ce froze out is taken up at the first edge with ce high, if psel is still set
                if (psel) begin
                    nxt_st.apb    = ST_ACCESS;
                    nxt_st.slverr = ~addr_mapped(paddr);
                    nxt_st.prdata = 8'h00;
                    if (paddr == `ADDR_CTRL_LOW) begin
                        nxt_st.prdata = ctrl_low_val;
                    end else if (paddr == `ADDR_CTRL_HIGH) begin
                        // unused low bits stay zero
                        nxt_st.prdata[`BIT_DBL_BUF] = st_ff.dbl;
                        nxt_st.prdata[`BIT_ISO_MODE] = st_ff.iso;
                    end else if (paddr == `ADDR_COUNT_LOW) begin
                        nxt_st.prdata = rx_byte_count[7:0];
                    end else if (paddr == `ADDR_COUNT_HIGH) begin
                        nxt_st.prdata = {6'h00, rx_byte_count[9:8]};
                    end
                end
            end
            ST_ACCESS: begin
                if (acc_done) begin
                    nxt_st.apb = ST_IDLE;
                end
            end
        endcase
        // only the two top bits of control high are kept
        if (wr_high) begin
            nxt_st.dbl = pwdata[`BIT_DBL_BUF];
            nxt_st.iso = pwdata[`BIT_ISO_MODE];
        end
        // flush runs for exactly one cycle, then clears itself
        if (st_ff.flush_pend) begin
            nxt_st.flush_pend = 1'b0;
        end else if (wr_low && pwdata[`BIT_FLUSH]) begin
            nxt_st.flush_pend = 1'b1;
        end
        // a drop in the clearing cycle still leaves the flag set
        if (wr_low && !pwdata[`BIT_LOST_PKT]) begin
            nxt_st.lost = 1'b0;
        end
        if (rx_valid && ce && out_buffer_full && st_ff.iso) begin
            nxt_st.lost = 1'b1;
        end
    end

    // ======================================================
    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff        <= '0;
            st_ff.apb    <= ST_IDLE;
            st_ff.prdata <= `CTRL_HIGH_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================
    // packet length store; its outputs move with ready and full
    pkt_len_queue u_queue (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .push     (push),
        .push_len (rx_len),
        .pop      (pop),
        .count    (q_count),
        .head_len (q_head)
    );

    // ======================================================
    // checks
    a_lost_on_drop: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_valid && ce && out_buffer_full && st_ff.iso)
        |=> lost_packet_flag)
        else $error("drop in iso mode did not set lost flag");

    a_lost_bulk_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!lost_packet_flag && !st_ff.iso) |=> !lost_packet_flag)
        else $error("lost flag set outside iso mode");

    a_full_by_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_buffer_full == (double_buffer_enable ?
                            (q_count == 2'h2) : (q_count != 2'h0)))
        else $error("full flag disagrees with occupancy");

    a_ready_on_push: assert property (
        @(posedge pclk) disable iff (!presetn)
        push |=> packet_ready_flag)
        else $error("stored packet did not raise ready");

    a_ctrl_high_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_high |=> (double_buffer_enable == $past(pwdata[7])) &&
                    (iso_mode == $past(pwdata[6])))
        else $error("control high write not stored");

    a_ctrl_high_rd: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == `ADDR_CTRL_HIGH)
        |-> (prdata[5:0] == 6'h00) && (prdata[7] == st_ff.dbl))
        else $error("control high read value wrong");

    a_count_rd: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && ce && st_ff.apb == ST_IDLE &&
         paddr == `ADDR_COUNT_LOW)
        |=> prdata[7:0] == $past(rx_byte_count[7:0]))
        else $error("count low read value wrong");

    a_count_high_rd: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && paddr == `ADDR_COUNT_HIGH)
        |-> prdata[7:2] == 6'h00)
        else $error("count high upper bits not zero");

    a_flush_done: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flush_req && ce && q_count == 2'h1 && !push)
        |=> !flush_req && !packet_ready_flag)
        else $error("flush did not complete in one cycle");

    a_count_with_rdy: assert property (
        @(posedge pclk) disable iff (!presetn)
        (push && q_count == 2'h0)
        |=> packet_ready_flag && (rx_byte_count == $past(rx_len)))
        else $error("count not valid with ready");

    // ======================================================
    // hold, stall, clear, flush and read checks; they catch a flag that moves on its own or fails to move when written
    a_lost_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lost_packet_flag && !wr_low) |=> lost_packet_flag)
        else $error("lost flag dropped without a clear");

    a_lost_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_low && !pwdata[`BIT_LOST_PKT] &&
         !(rx_valid && out_buffer_full && st_ff.iso))
        |=> !lost_packet_flag)
        else $error("lost flag clear not applied");

    a_full_stalls: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_buffer_full |-> !rx_ready)
        else $error("engine not stalled while full");

    a_full_has_pkt: assert property (
        @(posedge pclk) disable iff (!presetn)
        out_buffer_full |-> packet_ready_flag)
        else $error("full shown with no packet held");

    a_ready_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (packet_ready_flag && !pop) |=> packet_ready_flag)
        else $error("ready fell without release or flush");

    a_release_pop: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_low && !pwdata[`BIT_PKT_READY] && q_count == 2'h1 && !push)
        |=> !packet_ready_flag)
        else $error("release of last packet left ready set");

    a_dbl_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_high |=> $stable(double_buffer_enable))
        else $error("double buffer bit moved without a write");

    a_iso_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_high |=> $stable(iso_mode))
        else $error("iso bit moved without a write");

    a_count_high_val: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && ce && st_ff.apb == ST_IDLE && paddr == `ADDR_COUNT_HIGH)
        |=> prdata[1:0] == $past(rx_byte_count[9:8]))
        else $error("count high read value wrong");

    a_flush_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_low && pwdata[`BIT_FLUSH] && !flush_req) |=> flush_req)
        else $error("flush write did not start a flush");

    a_flush_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flush_req && ce) |=> !flush_req)
        else $error("flush control did not return to zero");

    a_count_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !packet_ready_flag |-> rx_byte_count == `COUNT_RST)
        else $error("count not zero with no packet held");

endmodule : usb_out_ep_status

//--- usb_out_ep_regs.svh
`ifndef USB_OUT_EP_REGS_SVH
`define USB_OUT_EP_REGS_SVH

// ==========================================================
// register indices; the byte address is four times the index
`define IDX_CTRL_LOW    8'h14
`define IDX_CTRL_HIGH   8'h15
`define IDX_COUNT_LOW   8'h16
`define IDX_COUNT_HIGH  8'h17
`define ADDR_CTRL_LOW   (`IDX_CTRL_LOW << 2)
`define ADDR_CTRL_HIGH  (`IDX_CTRL_HIGH << 2)
`define ADDR_COUNT_LOW  (`IDX_COUNT_LOW << 2)
`define ADDR_COUNT_HIGH (`IDX_COUNT_HIGH << 2)

// ==========================================================
// control low byte fields
`define BIT_PKT_READY   0
`define BIT_BUF_FULL    1
`define BIT_LOST_PKT    2
`define BIT_FLUSH       4
// control high byte fields
`define BIT_DBL_BUF     7
`define BIT_ISO_MODE    6
`define CTRL_HIGH_RST   8'h00
`define COUNT_RST       10'h000

// ==========================================================
// fifo occupancy limits, in packets
`define PKTS_SINGLE     2'h1
`define PKTS_DOUBLE     2'h2

`endif

//--- usb_out_ep_pkg.sv
package usb_out_ep_pkg;

    // ======================================================
    // apb slave phase, gray coded
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01
    } apb_state_t;

    // ======================================================
    // packet length queue state
    typedef struct packed {
        logic [1:0][9:0] len_mem;
        logic            wr_ptr;
        logic            rd_ptr;
        logic [1:0]      count;
    } queue_state_t;

    // ======================================================
    // endpoint status block state
    typedef struct packed {
        apb_state_t      apb;
        logic [7:0]      prdata;
        logic            slverr;
        logic            dbl;
        logic            iso;
        logic            lost;
        logic            flush_pend;
    } ep_state_t;

endpackage : usb_out_ep_pkg

//--- pkt_len_queue.sv
`timescale 1ns/1ns
`include "usb_out_ep_regs.svh"

// two-entry store of received packet lengths, oldest first
module pkt_len_queue
    import usb_out_ep_pkg::*;
(
    // clock, reset and enable
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // fill side
    input  wire logic       push,
    input  wire logic [9:0] push_len,
    // drain side
    input  wire logic       pop,
    output logic      [1:0] count,
    output logic      [9:0] head_len
);

    queue_state_t st_ff;
    queue_state_t nxt_st;

    // ======================================================
    // pointer and occupancy update; caller never pushes when full
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.len_mem[st_ff.wr_ptr] = push_len;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop && (st_ff.count != 2'h0)) begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        if (push && !(pop && (st_ff.count != 2'h0))) begin
            nxt_st.count = st_ff.count + 2'h1;
        end else if (!push && pop && (st_ff.count != 2'h0)) begin
            nxt_st.count = st_ff.count - 2'h1;
        end
    end

    // ======================================================
    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign count    = st_ff.count;
    assign head_len = st_ff.len_mem[st_ff.rd_ptr];

endmodule : pkt_len_queue

//--- pkt_source.sv
`timescale 1ns/1ns

// ==========================================================
// usb host model: hands finished out packets to the endpoint
module pkt_source (
    // clock
    input  wire logic       pclk,
    // packet handoff; the host ignores rx_ready, as a real one would,
    // and only notes whether each packet was taken
    input  wire logic       rx_ready,
    output logic            rx_valid,
    output logic      [9:0] rx_len
);
    logic taken;

    initial begin
        rx_valid = 1'b0;
        rx_len   = 10'h3FF;
        taken    = 1'b0;
    end

    // one pulse per packet; the length shows junk outside the pulse
    // so that a stale value latched late can never pass for a match
    task send(input logic [9:0] n);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_len   <= n;
        @(posedge pclk);
        taken    <= rx_ready;
        rx_valid <= 1'b0;
        rx_len   <= ~n;
    endtask : send
endmodule : pkt_source

//--- tb_top.sv
`timescale 1ns/1ns
`include "usb_out_ep_regs.svh"

module tb_top
    import usb_out_ep_pkg::*;
;
    logic        pclk, presetn, ce, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, rx_valid, rx_ready, flush_req;
    logic        rdy, full, lost, dbl, iso;
    logic [9:0]  rx_len, cnt;
    logic [9:0]  ln [4];
    logic [32:0] expq [$];
    int          error_cnt, num_checks, n;

    // ======================================================
    // clock and parts
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    usb_out_ep_status dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_len(rx_len),
        .rx_ready(rx_ready), .flush_req(flush_req),
        .packet_ready_flag(rdy), .out_buffer_full(full),
        .lost_packet_flag(lost), .double_buffer_enable(dbl),
        .iso_mode(iso), .rx_byte_count(cnt));

    pkt_source src (.pclk(pclk), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_len(rx_len));

    // ======================================================
    // comparison and verdict
    task chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task test_done;
        // a read whose answer never came is a miss too
        if (expq.size() != 0) begin
            error_cnt++;
        end
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // read data is compared at the edge that completes the access
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            chk({pslverr, prdata}, expq.pop_front());
        end
    end

    // ======================================================
    // apb master; a read notes its expected {pslverr, prdata}
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] exp);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        if (!w) expq.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!pready) begin
            error_cnt++;
            test_done();
        end
    endtask : apb

    // status levels packed as {ready, full, lost, rx_ready, count};
    // with ce high the engine may hand over exactly when not full
    task st(input logic r, input logic f, input logic l,
            input logic [9:0] c);
        logic [32:0] seen;
        #1;
        seen = {19'h0, rdy, full, lost, rx_ready, cnt};
        chk(seen, {19'h0, r, f, l, ~f, c});
    endtask : st

    // ======================================================
    // main sequence
    initial begin
        {presetn, ce, psel, penable, pwrite} = 5'h08;
        paddr  = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h90EE));
        for (int i = 0; i < 4; i++) ln[i] = 10'($urandom);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // register reset values, unused bits, unmapped place
        apb(0, `ADDR_CTRL_HIGH, 0, 33'h0);
        apb(0, `ADDR_COUNT_LOW, 0, 33'h0);
        apb(1, `ADDR_CTRL_HIGH, 32'hFF, 0);
        #1 chk({dbl, iso}, 2'b11);
        apb(0, `ADDR_CTRL_HIGH, 0, 33'hC0);
        apb(1, `ADDR_COUNT_LOW, 32'hFF, 0);
        apb(0, `ADDR_COUNT_LOW, 0, 33'h0);
        apb(0, 8'h00, 0, 33'h1_0000_0000);
        // single buffer, bulk: one packet fills, a second is lost quietly
        apb(1, `ADDR_CTRL_HIGH, 32'h00, 0);
        #1 chk({dbl, iso}, 2'b00);
        src.send(ln[0]);
        st(1, 1, 0, ln[0]);
        chk(src.taken, 1);
        apb(0, `ADDR_COUNT_LOW, 0, {25'h0, ln[0][7:0]});
        apb(0, `ADDR_COUNT_HIGH, 0, {31'h0, ln[0][9:8]});
        src.send(ln[1]);
        st(1, 1, 0, ln[0]);
        chk(src.taken, 0);
        apb(1, `ADDR_CTRL_LOW, 32'h00, 0);
        st(0, 0, 0, 10'h0);
        // double buffer, iso: two fill, third overruns, flush drops one
        apb(1, `ADDR_CTRL_HIGH, 32'hC0, 0);
        #1 chk({dbl, iso}, 2'b11);
        src.send(ln[1]);
        st(1, 0, 0, ln[1]);
        // ce low freezes all state: a packet then is neither kept nor lost
        @(posedge pclk);
        ce <= 1'b0;
        src.send(ln[0]);
        #1 chk({rdy, full, lost, rx_ready, cnt}, {4'h8, ln[1]});
        chk(src.taken, 0);
        @(posedge pclk);
        ce <= 1'b1;
        src.send(ln[2]);
        st(1, 1, 0, ln[1]);
        chk(src.taken, 1);
        src.send(ln[3]);
        st(1, 1, 1, ln[1]);
        chk(src.taken, 0);
        apb(0, `ADDR_CTRL_LOW, 0, 33'h7);
        apb(1, `ADDR_CTRL_LOW, 32'h15, 0);
        #1 chk(flush_req, 1);
        @(posedge pclk);
        #1 chk(flush_req, 0);
        st(1, 0, 1, ln[2]);
        apb(1, `ADDR_CTRL_LOW, 32'h01, 0);
        st(1, 0, 0, ln[2]);
        apb(1, `ADDR_CTRL_LOW, 32'h00, 0);
        st(0, 0, 0, 10'h0);
        // a reset in mid-run returns controls, flags and count to zero
        src.send(ln[3]);
        st(1, 0, 0, ln[3]);
        @(posedge pclk);
        presetn <= 1'b0;
        #1 chk({rdy, full, lost, dbl, iso, cnt}, 15'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `ADDR_CTRL_HIGH, 0, 33'h0);
        repeat (3) @(posedge pclk);
        test_done();
    end

    // a hang anywhere ends the run as a failure
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule : tb_top
